// ==== hw/flash_protect_pkg.sv ====
// Constants, types and command codes for the flash write-protection block.
// Assumes a 4-Mbit array addressed by 24-bit flash addresses, one clock.
//
// Contract
// - Scheme select clear: protection comes from range fields, lock store ignored.
// - Complement set inverts the selected range: inside unprotected, outside protected.
// - Granule bit with 3-bit span code picks 4 kB or 64 kB range units.
// - Origin bit zero anchors range at top, one anchors it at address zero.
// - Protected addresses refuse program and erase; reads are never checked.
// - 64 kB units: 000 none, 001-011 64/128/256 kB at end, 100-111 all.
// - 4 kB units: 001-100 4/8/16/32 kB, 101 as 100, 110-111 all, 000 none.
// - Complement set protects what the same code leaves unprotected otherwise, except for the 4 kB block erases below.
// - Complement, 4 kB, top: block erases see region ending 077FFFh or 06FFFFh.
// - Complement, 4 kB, bottom: block erases see region starting 008000h or 010000h.
// - Scheme select set: the per-block lock store alone decides protection.
// - Opcode 36h sets one lock bit, opcode 39h clears one lock bit.
// - Host sends 24-bit address after 36h; device sets the covering lock bit.
// - Lock store has 38 bits: 16 low sub-blocks, 16 high, 6 middle blocks.
// - Every lock bit comes up set after reset.
// - Opcode 7Eh sets every lock bit, opcode 98h clears every lock bit.
// - Scheme select comes up clear, so the whole array starts unprotected.
// - Opcodes 3Ch/3Dh return 8-bit lock value MSB first, LSB set if locked.

package flash_protect_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int FLASH_ADDR_W = 24;
  localparam int ARRAY_W = 19;
  localparam logic [18:0] ARRAY_LAST = 19'h7ffff;
  localparam logic [19:0] ARRAY_SIZE = 20'h80000;
  localparam logic [19:0] SIZE_4K = 20'h01000;
  localparam logic [19:0] SIZE_32K = 20'h08000;
  localparam logic [19:0] SIZE_64K = 20'h10000;
  localparam logic [18:0] WIDE32_TOP_HI = 19'h77fff;
  localparam logic [18:0] WIDE64_TOP_HI = 19'h6ffff;
  localparam logic [18:0] WIDE32_BOT_LO = 19'h08000;
  localparam logic [18:0] WIDE64_BOT_LO = 19'h10000;

  // ----------------------------------------------------------------
  // Lock store
  // ----------------------------------------------------------------
  localparam int LOCK_BITS = 38;
  localparam logic [37:0] LOCK_RESET = 38'h3f_ffff_ffff;
  localparam logic [5:0] LOCK_HIGH_BASE = 6'h10;
  localparam logic [5:0] LOCK_MID_BASE = 6'h1f;
  localparam int QUERY_BITS = 8;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LOCK_ONE = 8'h36;
  localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;
  localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
  localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
  localparam logic [7:0] OP_QUERY_A = 8'h3c;
  localparam logic [7:0] OP_QUERY_B = 8'h3d;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] CFG_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] LOCK_LO_OFFSET = 4'h8;
  localparam logic [3:0] LOCK_HI_OFFSET = 4'hc;
  localparam int CFG_SCHEME_BIT = 0;
  localparam int CFG_COMPLEMENT_BIT = 1;
  localparam int CFG_GRANULE_BIT = 2;
  localparam int CFG_BOTTOM_BIT = 3;
  localparam int CFG_SPAN_LSB = 4;
  localparam int STATUS_REFUSED_BIT = 0;
  localparam int STATUS_QUERY_BIT = 1;
  localparam logic [6:0] CFG_RESET = 7'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_PROGRAM = 3'h0,
    KIND_ERASE_4K = 3'h1,
    KIND_ERASE_32K = 3'h2,
    KIND_ERASE_64K = 3'h3,
    KIND_ERASE_CHIP = 3'h4
  } check_kind_type;

  typedef struct packed {
    logic protect_scheme_select;
    logic protect_complement;
    logic protect_granule_select;
    logic protect_from_bottom;
    logic [2:0] protect_span_code;
  } protect_cfg_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
  } lock_cmd_type;

  typedef struct packed {
    check_kind_type kind;
    logic [23:0] addr;
  } check_req_type;

endpackage

// ==== hw/flash_protect.sv ====
// Write-protection decision and lock store for the serial flash array.
// Assumes the command decoder and register master run on clk_in.
`timescale 1ns/10ps
`default_nettype none

module flash_protect (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [flash_protect_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Lock commands from the serial decoder
  input wire logic cmd_valid_in,
  input wire flash_protect_pkg::lock_cmd_type cmd_in,
  output logic cmd_ready_out,
  // Lock value answer, MSB first
  output logic query_bit_out,
  output logic query_valid_out,
  // Program and erase checks
  input wire logic chk_valid_in,
  input wire flash_protect_pkg::check_req_type chk_in,
  output logic chk_done_out,
  output logic chk_refused_out
);

  // ----------------------------------------------------------------
  // Lock index decoding
  // ----------------------------------------------------------------
  function automatic logic [5:0] lock_index(input logic [23:0] addr);
    logic [2:0] blk;
    logic [3:0] sub;
    blk = addr[18:16];
    sub = addr[15:12];
    if (blk == 3'h0)
    begin
      lock_index = {2'h0, sub};
    end
    else if (blk == 3'h7)
    begin
      lock_index = flash_protect_pkg::LOCK_HIGH_BASE + {2'h0, sub};
    end
    else
    begin
      lock_index = flash_protect_pkg::LOCK_MID_BASE + {3'h0, blk};
    end
  endfunction

  // Lock bits touched by a program or erase at addr
  function automatic logic [37:0] lock_mask(input flash_protect_pkg::check_kind_type kind,
                                            input logic [23:0] addr);
    logic [5:0] idx;
    logic [5:0] base;
    logic outer;
    idx = lock_index(addr);
    outer = (addr[18:16] == 3'h0) || (addr[18:16] == 3'h7);
    base = (addr[18:16] == 3'h7) ? flash_protect_pkg::LOCK_HIGH_BASE : 6'h00;
    lock_mask = 38'h1 << idx;
    unique case (kind)
      flash_protect_pkg::KIND_ERASE_32K:
      begin
        if (outer)
        begin
          lock_mask = 38'hff << (base + {2'h0, addr[15], 3'h0});
        end
      end
      flash_protect_pkg::KIND_ERASE_64K:
      begin
        if (outer)
        begin
          lock_mask = 38'hffff << base;
        end
      end
      flash_protect_pkg::KIND_ERASE_CHIP:
      begin
        lock_mask = flash_protect_pkg::LOCK_RESET;
      end
      default:
      begin
        lock_mask = 38'h1 << idx;
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  flash_protect_pkg::protect_cfg_type cfg_q;
  logic refused_q;
  logic [37:0] lock_q;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_q <= flash_protect_pkg::CFG_RESET;
    end
    else if (reg_wr_in && reg_addr_in == flash_protect_pkg::CFG_OFFSET)
    begin
      cfg_q.protect_scheme_select <= reg_wdata_in[flash_protect_pkg::CFG_SCHEME_BIT];
      cfg_q.protect_complement <= reg_wdata_in[flash_protect_pkg::CFG_COMPLEMENT_BIT];
      cfg_q.protect_granule_select <= reg_wdata_in[flash_protect_pkg::CFG_GRANULE_BIT];
      cfg_q.protect_from_bottom <= reg_wdata_in[flash_protect_pkg::CFG_BOTTOM_BIT];
      cfg_q.protect_span_code <= reg_wdata_in[flash_protect_pkg::CFG_SPAN_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Lock value query shifter
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    Q_IDLE = 2'b01,
    Q_SHIFT = 2'b10
  } query_state_type;

  query_state_type q_state_q;
  logic [7:0] q_shift_q;
  logic [2:0] q_count_q;
  logic cmd_take;
  logic is_query;

  assign cmd_ready_out = (q_state_q == Q_IDLE);
  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign is_query = (cmd_in.opcode == flash_protect_pkg::OP_QUERY_A) ||
                    (cmd_in.opcode == flash_protect_pkg::OP_QUERY_B);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q_state_q <= Q_IDLE;
      q_shift_q <= 8'h00;
      q_count_q <= 3'h0;
    end
    else
    begin
      unique case (q_state_q)
        Q_IDLE:
        begin
          if (cmd_take && is_query)
          begin
            q_shift_q <= {7'h00, lock_q[lock_index(cmd_in.addr)]};
            q_count_q <= 3'(flash_protect_pkg::QUERY_BITS - 1);
            q_state_q <= Q_SHIFT;
          end
        end
        Q_SHIFT:
        begin
          q_shift_q <= {q_shift_q[6:0], 1'b0};
          q_count_q <= q_count_q - 3'h1;
          if (q_count_q == 3'h0)
          begin
            q_state_q <= Q_IDLE;
          end
        end
        default:
        begin
          q_state_q <= Q_IDLE;
        end
      endcase
    end
  end

  assign query_bit_out = q_shift_q[7];
  assign query_valid_out = (q_state_q == Q_SHIFT);

  // ----------------------------------------------------------------
  // Lock store
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lock_q <= flash_protect_pkg::LOCK_RESET;
    end
    else if (cmd_take)
    begin
      unique case (cmd_in.opcode)
        flash_protect_pkg::OP_LOCK_ONE:
        begin
          lock_q[lock_index(cmd_in.addr)] <= 1'b1;
        end
        flash_protect_pkg::OP_UNLOCK_ONE:
        begin
          lock_q[lock_index(cmd_in.addr)] <= 1'b0;
        end
        flash_protect_pkg::OP_LOCK_ALL:
        begin
          lock_q <= flash_protect_pkg::LOCK_RESET;
        end
        flash_protect_pkg::OP_UNLOCK_ALL:
        begin
          lock_q <= 38'h0;
        end
        default:
        begin
          lock_q <= lock_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Standard range decode
  // ----------------------------------------------------------------
  logic [19:0] span_size;
  logic span_none;
  logic span_all;
  logic prot_none;
  logic [18:0] prot_lo;
  logic [18:0] prot_hi;
  logic [19:0] top_start;
  logic [19:0] span_end;
  logic [2:0] code;

  always_comb
  begin
    code = cfg_q.protect_span_code;
    span_none = (code == 3'h0);
    span_all = 1'b0;
    span_size = flash_protect_pkg::SIZE_64K;
    if (cfg_q.protect_granule_select)
    begin
      unique case (code)
        3'h1: span_size = flash_protect_pkg::SIZE_4K;
        3'h2: span_size = flash_protect_pkg::SIZE_4K << 1;
        3'h3: span_size = flash_protect_pkg::SIZE_4K << 2;
        3'h4, 3'h5: span_size = flash_protect_pkg::SIZE_32K;
        3'h6, 3'h7: span_all = 1'b1;
        default: span_size = flash_protect_pkg::SIZE_4K;
      endcase
    end
    else
    begin
      unique case (code)
        3'h1: span_size = flash_protect_pkg::SIZE_64K;
        3'h2: span_size = flash_protect_pkg::SIZE_64K << 1;
        3'h3: span_size = flash_protect_pkg::SIZE_64K << 2;
        3'h4, 3'h5, 3'h6, 3'h7: span_all = 1'b1;
        default: span_size = flash_protect_pkg::SIZE_64K;
      endcase
    end
    top_start = flash_protect_pkg::ARRAY_SIZE - span_size;
    span_end = span_size - 20'h1;
    prot_none = 1'b0;
    prot_lo = 19'h0;
    prot_hi = flash_protect_pkg::ARRAY_LAST;
    if (!cfg_q.protect_complement)
    begin
      if (span_none)
      begin
        prot_none = 1'b1;
      end
      else if (!span_all && !cfg_q.protect_from_bottom)
      begin
        prot_lo = top_start[18:0];
      end
      else if (!span_all)
      begin
        prot_hi = span_end[18:0];
      end
    end
    else
    begin
      if (span_all)
      begin
        prot_none = 1'b1;
      end
      else if (!span_none && !cfg_q.protect_from_bottom)
      begin
        prot_hi = top_start[18:0] - 19'h1;
      end
      else if (!span_none)
      begin
        prot_lo = span_size[18:0];
      end
    end
    if (cfg_q.protect_complement && cfg_q.protect_granule_select &&
        !span_none && !span_all)
    begin
      if (chk_in.kind == flash_protect_pkg::KIND_ERASE_32K && code <= 3'h3)
      begin
        if (cfg_q.protect_from_bottom)
        begin
          prot_lo = flash_protect_pkg::WIDE32_BOT_LO;
        end
        else
        begin
          prot_hi = flash_protect_pkg::WIDE32_TOP_HI;
        end
      end
      if (chk_in.kind == flash_protect_pkg::KIND_ERASE_64K)
      begin
        if (cfg_q.protect_from_bottom)
        begin
          prot_lo = flash_protect_pkg::WIDE64_BOT_LO;
        end
        else
        begin
          prot_hi = flash_protect_pkg::WIDE64_TOP_HI;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Target region and verdict
  // ----------------------------------------------------------------
  logic [19:0] region_span;
  logic [18:0] region_lo;
  logic [18:0] region_hi;
  logic std_hit;
  logic lock_hit;
  logic refuse;

  always_comb
  begin
    unique case (chk_in.kind)
      flash_protect_pkg::KIND_ERASE_4K: region_span = flash_protect_pkg::SIZE_4K - 20'h1;
      flash_protect_pkg::KIND_ERASE_32K: region_span = flash_protect_pkg::SIZE_32K - 20'h1;
      flash_protect_pkg::KIND_ERASE_64K: region_span = flash_protect_pkg::SIZE_64K - 20'h1;
      flash_protect_pkg::KIND_ERASE_CHIP: region_span = flash_protect_pkg::ARRAY_SIZE - 20'h1;
      default: region_span = 20'h0;
    endcase
    region_lo = chk_in.addr[18:0] & ~region_span[18:0];
    region_hi = region_lo | region_span[18:0];
  end

  assign std_hit = !prot_none && (region_lo <= prot_hi) && (region_hi >= prot_lo);
  assign lock_hit = |(lock_q & lock_mask(chk_in.kind, chk_in.addr));
  assign refuse = cfg_q.protect_scheme_select ? lock_hit : std_hit;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      chk_done_out <= 1'b0;
      chk_refused_out <= 1'b0;
    end
    else
    begin
      chk_done_out <= chk_valid_in;
      chk_refused_out <= chk_valid_in && refuse;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      refused_q <= 1'b0;
    end
    else if (chk_valid_in)
    begin
      refused_q <= refuse;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= 32'h0;
    end
    else if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        flash_protect_pkg::CFG_OFFSET:
        begin
          reg_rdata_out <= {25'h0, cfg_q.protect_span_code, cfg_q.protect_from_bottom,
                            cfg_q.protect_granule_select, cfg_q.protect_complement,
                            cfg_q.protect_scheme_select};
        end
        flash_protect_pkg::STATUS_OFFSET:
        begin
          reg_rdata_out <= {30'h0, (q_state_q == Q_SHIFT), refused_q};
        end
        flash_protect_pkg::LOCK_LO_OFFSET:
        begin
          reg_rdata_out <= lock_q[31:0];
        end
        flash_protect_pkg::LOCK_HI_OFFSET:
        begin
          reg_rdata_out <= {26'h0, lock_q[37:32]};
        end
        default:
        begin
          reg_rdata_out <= 32'h0;
        end
      endcase
    end
    else
    begin
      reg_rdata_out <= 32'h0;
    end
  end

endmodule

`default_nettype wire

// ==== verif/flash_protect_asserts.sv ====
// Port checker for the flash write-protection block.
// Assumes it is bound onto flash_protect; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module flash_protect_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Lock commands
  input wire logic cmd_valid_in,
  input wire flash_protect_pkg::lock_cmd_type cmd_in,
  input wire logic cmd_ready_out,
  input wire logic query_bit_out,
  input wire logic query_valid_out,
  // Checks
  input wire logic chk_valid_in,
  input wire flash_protect_pkg::check_req_type chk_in,
  input wire logic chk_done_out,
  input wire logic chk_refused_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire taken = cmd_valid_in && cmd_ready_out;

  chk_answer_time:
    assert property (chk_valid_in |=> chk_done_out) else $error("check answer missing");
  chk_answer_cause:
    assert property (chk_done_out |-> $past(chk_valid_in)) else $error("stray check answer");
  chk_refuse_qual:
    assert property (chk_refused_out |-> chk_done_out) else $error("stray verdict");
  chk_query_len:
    assert property (taken && cmd_in.opcode inside {8'h3c, 8'h3d} |=>
      query_valid_out [*8] ##1 !query_valid_out) else $error("lock answer length wrong");
  chk_query_busy:
    assert property (query_valid_out |-> !cmd_ready_out) else $error("ready while shifting");
  chk_query_lead:
    assert property ($rose(query_valid_out) |-> !query_bit_out [*7])
      else $error("lock answer upper bits set");
  chk_lockall_read:
    assert property (taken && cmd_in.opcode == 8'h7e ##[1:2] reg_rd_in && reg_addr_in == 4'h8
      |=> reg_rdata_out == 32'hffff_ffff) else $error("global lock incomplete");
  chk_unlockall_read:
    assert property (taken && cmd_in.opcode == 8'h98 ##[1:2] reg_rd_in && reg_addr_in == 4'h8
      |=> reg_rdata_out == 32'h0) else $error("global unlock incomplete");
  chk_rdata_idle:
    assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("stray read data");

  cover property (chk_done_out && chk_refused_out);
  cover property ($rose(query_valid_out));
  cover property (taken && cmd_in.opcode == 8'h98);
endmodule

bind flash_protect flash_protect_asserts flash_protect_asserts_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .cmd_ready_out(cmd_ready_out), .query_bit_out(query_bit_out),
  .query_valid_out(query_valid_out), .chk_valid_in(chk_valid_in), .chk_in(chk_in),
  .chk_done_out(chk_done_out), .chk_refused_out(chk_refused_out)
);
`default_nettype wire

// ==== verif/lock_cmd_host.sv ====
// Serial host model issuing lock commands and collecting lock answers.
// Assumes a command is taken on an edge with valid and ready high.
`timescale 1ns/10ps
`default_nettype none
module lock_cmd_host (
  // Clock
  input wire logic clk_in,
  // Command handshake
  input wire logic cmd_ready_in,
  output var logic cmd_valid_out,
  output var flash_protect_pkg::lock_cmd_type cmd_out,
  // Lock answer
  input wire logic query_bit_in,
  input wire logic query_valid_in
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end

  task automatic send(input logic [7:0] op, input logic [23:0] ad);
    int n;
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_out <= {op, ad};
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (!cmd_ready_in && n < 40);
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_out <= ~cmd_out;
  endtask

  task automatic query(input logic [7:0] op, input logic [23:0] ad, output logic [7:0] v);
    v = 'x;
    send(op, ad);
    for (int n = 0; n < 12; n++)
    begin
      @(negedge clk_in);
      if (query_valid_in === 1'b1)
        v = {v[6:0], query_bit_in};
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the flash write-protection block.
// Assumes the bound checker and the host model beside the design.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic chk_valid_in = 1'b0;
  flash_protect_pkg::check_req_type chk_in = '0;
  flash_protect_pkg::lock_cmd_type cmd_in;
  logic [31:0] reg_rdata_out;
  logic cmd_valid_in, cmd_ready_out, query_bit_out, query_valid_out;
  logic chk_done_out, chk_refused_out;
  int error_cnt = 0;
  int total_checks = 0;
  logic [6:0] cfg;
  logic [37:0] locks;
  logic [31:0] rd;
  logic [7:0] qv;
  logic [23:0] a;
  logic [7:0] ops [6] = '{8'h36, 8'h39, 8'h39, 8'h39, 8'h7e, 8'h98};
  logic [23:0] corner [9] = '{24'h000000, 24'h07ffff, 24'h06f000, 24'h070000,
    24'h077000, 24'h078000, 24'h008000, 24'h00f000, 24'h010000};

  always #20 clk_in = ~clk_in;

  flash_protect flash_protect_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .query_bit_out(query_bit_out),
    .query_valid_out(query_valid_out), .chk_valid_in(chk_valid_in), .chk_in(chk_in),
    .chk_done_out(chk_done_out), .chk_refused_out(chk_refused_out));
  lock_cmd_host lock_cmd_host_i (.clk_in(clk_in), .cmd_ready_in(cmd_ready_out),
    .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in), .query_bit_in(query_bit_out),
    .query_valid_in(query_valid_out));

  // ----------------------------------------
  // Expectation
  // ----------------------------------------
  function automatic int lock_idx(logic [6:0] b);
    if (b[6:4] == 3'h0)
      return int'(b[3:0]);
    if (b[6:4] == 3'h7)
      return 16 + int'(b[3:0]);
    return 31 + int'(b[6:4]);
  endfunction

  function automatic logic exp_refused(logic [6:0] c, logic [37:0] lk, logic [2:0] k,
                                       logic [23:0] ad);
    logic [19:0] sz, es, lo, hi, rl, rh;
    logic hit;
    logic [2:0] cd;
    cd = c[6:4];
    es = k == 3'h0 ? 20'h1 : k == 3'h1 ? 20'h1000 : k == 3'h2 ? 20'h8000 :
      k == 3'h3 ? 20'h10000 : 20'h80000;
    lo = {1'b0, ad[18:0]} & ~(es - 20'h1);
    hi = lo + es - 20'h1;
    if (c[0])
    begin
      hit = 1'b0;
      for (int i = 0; i < 128; i++)
        if ({i[6:0], 12'h0} <= hi && {i[6:0], 12'hfff} >= lo)
          hit |= lk[lock_idx(i[6:0])];
      return hit;
    end
    if (c[2])
      sz = cd == 3'h0 ? 20'h0 : cd < 3'h4 ? 20'h1000 << (cd - 3'h1) :
        cd < 3'h6 ? 20'h8000 : 20'h80000;
    else
      sz = cd == 3'h0 ? 20'h0 : cd < 3'h4 ? 20'h10000 << (cd - 3'h1) : 20'h80000;
    if (c[1] && c[2] && k == 3'h3 && cd != 3'h0 && cd < 3'h6)
      sz = 20'h10000;
    if (c[1] && c[2] && k == 3'h2 && cd != 3'h0 && cd < 3'h4)
      sz = 20'h8000;
    rl = c[3] ? 20'h0 : 20'h80000 - sz;
    rh = rl + sz - 20'h1;
    if (c[1])
      return !(sz != 20'h0 && lo >= rl && hi <= rh);
    return sz != 20'h0 && lo <= rh && hi >= rl;
  endfunction

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic reg_write(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= ad;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    d = reg_rdata_out;
  endtask

  task automatic do_chk(input logic [2:0] k, input logic [23:0] ad);
    logic e;
    e = exp_refused(cfg, locks, k, ad);
    @(posedge clk_in);
    chk_valid_in <= 1'b1;
    chk_in <= {k, ad};
    @(posedge clk_in);
    chk_valid_in <= 1'b0;
    @(negedge clk_in);
    `CHECK(chk_done_out, 1'b1)
    `CHECK(chk_refused_out, e)
  endtask

  task automatic cmd(input logic [7:0] o, input logic [23:0] ad);
    lock_cmd_host_i.send(o, ad);
    case (o)
      8'h36: locks[lock_idx(ad[18:12])] = 1'b1;
      8'h39: locks[lock_idx(ad[18:12])] = 1'b0;
      8'h7e: locks = '1;
      8'h98: locks = '0;
      default: ;
    endcase
  endtask

  task automatic check_store();
    reg_read(4'h8, rd);
    `CHECK(rd, locks[31:0])
    reg_read(4'hc, rd);
    `CHECK(rd[5:0], locks[37:32])
  endtask

  task automatic do_reset();
    if (rst_n_in)
      @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cfg = 7'h0;
    locks = '1;
    reg_read(4'h0, rd);
    `CHECK(rd, 32'h0)
    check_store();
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(30470));
    do_reset();
    reg_read(4'h2, rd);
    `CHECK(rd, 32'h0)
    reg_write(4'h8, 32'h0);
    check_store();
    for (int c = 0; c < 64; c++)
    begin
      cfg = {c[5:0], 1'b0};
      reg_write(4'h0, {25'h0, cfg});
      reg_read(4'h0, rd);
      `CHECK(rd[6:0], cfg)
      for (int k = 0; k < 5; k++)
        for (int j = 0; j < 10; j++)
        begin
          a = (j < 9) ? corner[j] : 24'($urandom());
          do_chk(k[2:0], a | (24'($urandom()) & 24'hf80000));
        end
      reg_read(4'h4, rd);
      `CHECK(rd[0], exp_refused(cfg, locks, 3'h4, 24'h0))
    end
    cfg = 7'($urandom()) | 7'h1;
    reg_write(4'h0, {25'h0, cfg});
    cmd(8'h98, 24'h0);
    check_store();
    for (int i = 0; i < 150; i++)
    begin
      a = 24'($urandom());
      cmd(ops[$urandom_range(5)], a);
      check_store();
      lock_cmd_host_i.query(i[0] ? 8'h3c : 8'h3d, a, qv);
      `CHECK(qv, {7'h0, locks[lock_idx(a[18:12])]})
      do_chk(3'($urandom_range(4)), 24'($urandom()));
    end
    do_reset();
    do_chk(3'h4, 24'h0);
    report_and_stop();
  end

  initial
  begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
